// ===== core/dac_load_pkg.sv
// package: constants and carrier types for the dac serial load port
// ****************************************************************
// ****************************************************************
package dac_load_pkg;
	localparam int unsigned FRAME_BITS    = 16;
	localparam int unsigned DATA_BITS     = 10;
	localparam int unsigned CHAN_BITS     = 3;
	localparam int unsigned NUM_CHAN      = 8;
	localparam int unsigned CHAN_POS      = 12;
	localparam int unsigned DATA_POS      = 0;
	localparam logic [4:0]  BIT_CNT_RESET = 5'h00;
	localparam logic [DATA_BITS-1:0] DATA_RESET = 10'h000;

	// one decoded serial word
	typedef struct packed {
		logic [CHAN_BITS-1:0] chan;
		logic [DATA_BITS-1:0] data;
	} dac_word_t;

	// synchronised link pins
	typedef struct packed {
		logic sclk;
		logic sdata;
		logic fsync_n;
		logic load_n;
	} link_pins_t;

	// pin levels while idle or in reset: serial clock low, frame and load strobes inactive
	localparam link_pins_t PINS_IDLE = 4'h3;
endpackage : dac_load_pkg

// ===== core/pin_sync.sv
// two-stage synchroniser for the link pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
	// clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   srst_in,
	// pins
	input  wire dac_load_pkg::link_pins_t pins_in,
	output var  dac_load_pkg::link_pins_t pins_out
);
	dac_load_pkg::link_pins_t meta_reg;
	dac_load_pkg::link_pins_t meta_next;
	dac_load_pkg::link_pins_t sync_reg;
	dac_load_pkg::link_pins_t sync_next;

	// idle values: frame and load strobes inactive
	always_comb begin
		meta_next = srst_in ? dac_load_pkg::PINS_IDLE : pins_in;
		sync_next = srst_in ? dac_load_pkg::PINS_IDLE : meta_reg;
	end

	// first stage feeds only the second stage
	always_ff @(posedge clk_in) begin
		meta_reg <= meta_next;
		sync_reg <= sync_next;
	end

	assign pins_out = sync_reg;
endmodule : pin_sync
`default_nettype wire

// ===== core/dac_serial_load_port.sv
// serial load port: shifter, input registers and output registers
`timescale 1ns/10ps
`default_nettype none
module dac_serial_load_port (
	// clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         srst_in,
	// serial link pins
	input  wire logic                         serial_clock_input_in,
	input  wire logic                         serial_data_input_in,
	input  wire logic                         frame_sync_n_in,
	input  wire logic                         load_outputs_n_in,
	// dac output codes, all channels packed
	output var  logic [8*10-1:0]              dac_code_out,
	// status
	output var  logic                         frame_done_out,
	output var  logic                         frame_error_out
);
	// ****************************************************************
	// pin synchronisation
	// ****************************************************************
	dac_load_pkg::link_pins_t pins_raw;
	dac_load_pkg::link_pins_t pins;

	assign pins_raw = '{sclk: serial_clock_input_in, sdata: serial_data_input_in,
		fsync_n: frame_sync_n_in, load_n: load_outputs_n_in};

	pin_sync u_sync (
		.clk_in   (clk_in),
		.srst_in  (srst_in),
		.pins_in  (pins_raw),
		.pins_out (pins)
	);

	// ****************************************************************
	// edge detection on the synchronised pins
	// ****************************************************************
	logic                                    sclk_d_reg;
	logic                                    sclk_d_next;
	logic                                    load_d_reg;
	logic                                    load_d_next;
	logic                                    fall;
	logic                                    load_fall;

	// delayed copies restart at the idle pin levels, so reset leaves no false edge
	always_comb begin
		sclk_d_next = pins.sclk;
		load_d_next = pins.load_n;
		if (srst_in) begin
			sclk_d_next = dac_load_pkg::PINS_IDLE.sclk;
			load_d_next = dac_load_pkg::PINS_IDLE.load_n;
		end
	end

	// register the delayed copies
	always_ff @(posedge clk_in) begin
		sclk_d_reg <= sclk_d_next;
		load_d_reg <= load_d_next;
	end

	// one-cycle strobes; each serial clock phase must span three system clocks
	assign fall      = sclk_d_reg & ~pins.sclk;
	assign load_fall = load_d_reg & ~pins.load_n;

	// ****************************************************************
	// shifter
	// ****************************************************************
	logic [dac_load_pkg::FRAME_BITS-1:0]     shift_reg;
	logic [dac_load_pkg::FRAME_BITS-1:0]     shift_next;
	logic [dac_load_pkg::FRAME_BITS-1:0]     shift_in;
	logic [4:0]                              bit_cnt_reg;
	logic [4:0]                              bit_cnt_next;
	logic                                    word_ok_reg;
	logic                                    word_ok_next;
	dac_load_pkg::dac_word_t                 word_reg;
	dac_load_pkg::dac_word_t                 word_next;
	logic                                    word_end;
	logic                                    frame_bad;

	// extract channel and data from a finished word
	function automatic dac_load_pkg::dac_word_t decode_word(
		input logic [dac_load_pkg::FRAME_BITS-1:0] w);
		dac_load_pkg::dac_word_t r;
		r.chan = w[dac_load_pkg::CHAN_POS +: dac_load_pkg::CHAN_BITS];
		r.data = w[dac_load_pkg::DATA_POS +: dac_load_pkg::DATA_BITS];
		return r;
	endfunction : decode_word

	// new bit enters at the bottom, so the first bit sent ends up on top
	assign shift_in  = {shift_reg[dac_load_pkg::FRAME_BITS-2:0], pins.sdata};
	// sixteenth falling edge inside this device's frame, even across two bytes
	assign word_end  = ~pins.fsync_n & fall &
		(bit_cnt_reg == 5'(dac_load_pkg::FRAME_BITS - 1));
	// frame closed on a count other than none or sixteen
	assign frame_bad = pins.fsync_n & (bit_cnt_reg != dac_load_pkg::BIT_CNT_RESET) &
		(bit_cnt_reg != 5'(dac_load_pkg::FRAME_BITS));

	// shifter: counts bits only inside this device's frame
	always_comb begin
		shift_next   = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		word_ok_next = word_end;
		word_next    = word_reg;
		if (pins.fsync_n) begin
			// frame closed: a short frame never reaches an input register
			bit_cnt_next = dac_load_pkg::BIT_CNT_RESET;
		end else if (fall) begin
			shift_next = shift_in;
			if (word_end) begin
				word_next = decode_word(shift_in);
			end
			// count saturates so bits beyond sixteen never start a second word
			if (bit_cnt_reg != 5'h1F) begin
				bit_cnt_next = bit_cnt_reg + 5'h01;
			end
		end
		if (srst_in) begin
			shift_next   = '0;
			bit_cnt_next = dac_load_pkg::BIT_CNT_RESET;
			word_ok_next = 1'b0;
			word_next    = '0;
		end
	end

	// register shift state
	always_ff @(posedge clk_in) begin
		shift_reg   <= shift_next;
		bit_cnt_reg <= bit_cnt_next;
		word_ok_reg <= word_ok_next;
		word_reg    <= word_next;
	end

	// ****************************************************************
	// frame status
	// ****************************************************************
	// status pulses for the host side, kept apart from the data path
	logic                                    done_reg;
	logic                                    done_next;
	logic                                    err_reg;
	logic                                    err_next;

	// both pulses last one cycle: the count they depend on moves on at once
	always_comb begin
		done_next = word_end;
		err_next  = frame_bad;
		if (srst_in) begin
			done_next = 1'b0;
			err_next  = 1'b0;
		end
	end

	// register status pulses
	always_ff @(posedge clk_in) begin
		done_reg <= done_next;
		err_reg  <= err_next;
	end

	// ****************************************************************
	// double-buffered channel registers
	// ****************************************************************
	logic [dac_load_pkg::DATA_BITS-1:0] in_reg   [dac_load_pkg::NUM_CHAN];
	logic [dac_load_pkg::DATA_BITS-1:0] in_next  [dac_load_pkg::NUM_CHAN];
	logic [dac_load_pkg::DATA_BITS-1:0] out_reg  [dac_load_pkg::NUM_CHAN];
	logic [dac_load_pkg::DATA_BITS-1:0] out_next [dac_load_pkg::NUM_CHAN];
	logic [dac_load_pkg::NUM_CHAN-1:0]  pend_reg;
	logic [dac_load_pkg::NUM_CHAN-1:0]  pend_next;

	// input register write, output transfer on strobe
	always_comb begin
		pend_next = pend_reg;
		for (int i = 0; i < dac_load_pkg::NUM_CHAN; i++) begin
			in_next[i]  = in_reg[i];
			out_next[i] = out_reg[i];
		end
		if (word_ok_reg) begin
			in_next[word_reg.chan]  = word_reg.data;
			pend_next[word_reg.chan] = 1'b1;
		end
		if (load_fall) begin
			// pulse: move all pending channels together
			for (int i = 0; i < dac_load_pkg::NUM_CHAN; i++) begin
				if (pend_reg[i]) begin
					out_next[i] = in_reg[i];
				end
			end
			pend_next = '0;
			if (word_ok_reg) begin
				pend_next[word_reg.chan] = 1'b1; // a new write keeps waiting
			end
		end else if (!pins.load_n && word_ok_reg) begin
			// strobe tied low: update right after the sixteenth clock
			out_next[word_reg.chan]  = word_reg.data;
			pend_next[word_reg.chan] = 1'b0;
		end
		if (srst_in) begin
			pend_next = '0;
			for (int i = 0; i < dac_load_pkg::NUM_CHAN; i++) begin
				in_next[i]  = dac_load_pkg::DATA_RESET;
				out_next[i] = dac_load_pkg::DATA_RESET;
			end
		end
	end

	// register channel state
	always_ff @(posedge clk_in) begin
		pend_reg <= pend_next;
		for (int i = 0; i < dac_load_pkg::NUM_CHAN; i++) begin
			in_reg[i]  <= in_next[i];
			out_reg[i] <= out_next[i];
		end
	end

	// ****************************************************************
	// outputs straight from flip-flops
	// ****************************************************************
	always_comb begin
		for (int i = 0; i < dac_load_pkg::NUM_CHAN; i++) begin
			dac_code_out[i*10 +: 10] = out_reg[i];
		end
	end

	assign frame_done_out  = done_reg;
	assign frame_error_out = err_reg;
endmodule : dac_serial_load_port
`default_nettype wire

// ===== verification/dac_port_assertions.sv
// checker: timing relations at the dac load port pins
`timescale 1ns/10ps
`default_nettype none
module dac_port_assertions (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        srst_in,
	// pins and status
	input wire logic        frame_sync_n_in,
	input wire logic        load_outputs_n_in,
	input wire logic [79:0] dac_code_out,
	input wire logic        frame_done_out,
	input wire logic        frame_error_out
);
	// ****
	// checks
	// ****
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// eight idle cycles outlast the two sync stages and the register
	sequence s_fs_idle;
		frame_sync_n_in [*8];
	endsequence
	sequence s_load_idle;
		load_outputs_n_in [*8];
	endsequence
	a_reset_clear: assert property (disable iff (1'b0) srst_in |=>
		dac_code_out == '0 && !frame_done_out) else $error("reset did not clear");
	a_done_pulse: assert property (frame_done_out |=> !frame_done_out)
		else $error("done longer than one cycle");
	a_error_pulse: assert property (frame_error_out |=> !frame_error_out)
		else $error("error longer than one cycle");
	a_done_excl: assert property (!(frame_done_out && frame_error_out))
		else $error("done and error together");
	a_done_in_frame: assert property (frame_done_out |->
		$past(frame_sync_n_in, 5) == 1'b0) else $error("done outside a frame");
	a_quiet_no_done: assert property (s_fs_idle |-> !frame_done_out)
		else $error("done with frame sync high");
	a_error_after_frame: assert property (frame_error_out |->
		$past(frame_sync_n_in, 3)) else $error("error inside a frame");
	a_hold_outputs: assert property (s_load_idle |-> $stable(dac_code_out))
		else $error("outputs moved without strobe");
endmodule : dac_port_assertions
bind dac_serial_load_port dac_port_assertions dac_port_assertions_inst (
	.clk_in(clk_in), .srst_in(srst_in), .frame_sync_n_in(frame_sync_n_in),
	.load_outputs_n_in(load_outputs_n_in), .dac_code_out(dac_code_out),
	.frame_done_out(frame_done_out), .frame_error_out(frame_error_out));
`default_nettype wire

// ===== verification/host_model.sv
// host model: drives frames onto the serial link, msb first
`timescale 1ns/10ps
`default_nettype none
module host_model (
	// clock
	input  wire logic clk_in,
	// serial link
	output var  logic sclk_out,
	output var  logic sdata_out,
	output var  logic fs_n_out
);
	// idle link: clock low and still, frame sync high
	initial begin
		sclk_out = 1'b0;
		sdata_out = 1'b0;
		fs_n_out = 1'b1;
	end
	task automatic gap(input int k);
		repeat (k) @(negedge clk_in);
	endtask : gap
	// one frame; 60 ns high and 65 ns low give the 125 ns serial period, and the
	// 2.5 ns offset keeps every serial clock and data edge clear of both system clock edges
	task automatic frame(input logic [15:0] w, input int n, input bit split, input logic fs);
		fs_n_out = fs;
		gap(7);
		#2.5;
		for (int i = 0; i < n; i++) begin
			sclk_out = 1'b1;
			sdata_out = w[15-i];
			#60;
			sclk_out = 1'b0;
			#65;
			if (split && i == 7) #300;
		end
		sdata_out = ~sdata_out; // released line shows no stale bit
		gap(6);
		fs_n_out = 1'b1;
		gap(7);
	endtask : frame
endmodule : host_model
`default_nettype wire

// ===== verification/test_dac_serial_load_port.sv
// testbench: frames from the host model checked at the dac outputs
`timescale 1ns/10ps
`default_nettype none
module test_dac_serial_load_port;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        load_n = 1'b1;
	wire logic   sclk, sdata, fs_n;
	logic [79:0] dac_code;
	logic [79:0] exp_code = '0;
	logic        done, err;
	int          fails, cmp_count, done_cnt, err_cnt;
	always #5 clk_in = ~clk_in;
	// count pulses at the falling edge, where they stand settled; no exact latency needed
	always @(negedge clk_in) begin
		if (done === 1'b1) done_cnt++;
		if (err === 1'b1) err_cnt++;
	end
	host_model host_model_inst (.clk_in(clk_in), .sclk_out(sclk), .sdata_out(sdata),
		.fs_n_out(fs_n));
	dac_serial_load_port dac_serial_load_port_inst (.clk_in(clk_in), .srst_in(srst_in),
		.serial_clock_input_in(sclk), .serial_data_input_in(sdata),
		.frame_sync_n_in(fs_n), .load_outputs_n_in(load_n), .dac_code_out(dac_code),
		.frame_done_out(done), .frame_error_out(err));
	task chk(input string name, input logic [79:0] exp, input logic [79:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s exp %h got %h", name, exp, got);
		end
	endtask : chk
	task end_sim;
		$display("compares %0d, fails %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	// two channels loaded, outputs move only on one strobe pulse
	task t_held;
		host_model_inst.frame(16'h1155, 16, 1'b0, 1'b0);
		host_model_inst.frame(16'hEEAA, 16, 1'b1, 1'b0); // junk bits 15, 11:10
		chk("held", exp_code, dac_code);
		chk("done count", 80'(2), 80'(done_cnt));
		load_n = 1'b0;
		host_model_inst.gap(4);
		load_n = 1'b1;
		host_model_inst.gap(8);
		exp_code[19:10] = 10'h155;
		exp_code[69:60] = 10'h2AA;
		chk("strobe", exp_code, dac_code);
	endtask : t_held
	// strobe tied low: each word lands by itself
	task t_auto;
		load_n = 1'b0;
		host_model_inst.frame(16'h3201, 16, 1'b0, 1'b0);
		exp_code[39:30] = 10'h201;
		chk("auto", exp_code, dac_code);
	endtask : t_auto
	// foreign traffic and a short frame must leave outputs alone
	task t_refused;
		host_model_inst.frame(16'h7123, 16, 1'b0, 1'b1);
		host_model_inst.frame(16'h5155, 12, 1'b0, 1'b0);
		chk("refused", exp_code, dac_code);
		chk("error count", 80'(1), 80'(err_cnt));
		chk("done total", 80'(3), 80'(done_cnt));
	endtask : t_refused
	// main sequence
	initial begin
		host_model_inst.gap(12);
		srst_in = 1'b0;
		host_model_inst.gap(1);
		chk("reset", '0, dac_code);
		t_held();
		t_auto();
		t_refused();
		end_sim();
	end
	// watchdog well beyond the roughly 1100 cycles the tests take
	initial begin
		#100000;
		fails++;
		end_sim();
	end
endmodule : test_dac_serial_load_port
`default_nettype wire
